// File: logic/ewp_device.sv
// Memory device end of the three-wire serial command port
`timescale 1ns/10ps
`include "ewp_defines.svh"
module ewp_device
  import ewp_pkg::*;
#(
  parameter int TWP_CYCLES = `EWP_TWP_CYC
)
(
  // System
  input  wire logic  i_clk,
  input  wire logic  i_nrst,
  // Link
  ewp_if.dev         link,
  // Organisation strap
  input  wire logic  i_word_width_select,
  // Status
  output logic       o_busy,
  output logic       o_prog_enabled
);

  // ----------------------------------------
  // Link domain declarations
  // ----------------------------------------
  logic        lrst_n;
  logic [1:0]  org_sync;
  logic [1:0]  busy_sync;
  ewp_dev_st_e st;
  logic [4:0]  cnt;
  logic [7:0]  hdr_sr;
  logic [15:0] dat_sr;
  logic [1:0]  op_q;
  logic [6:0]  addr_q;
  logic        prog_en;
  logic        prog_tgl;
  logic        rd_bit;
  logic        rd_act;
  logic        cmd_seen;
  logic [15:0] mem [`EWP_WORDS];

  logic        x16;
  logic [4:0]  aw;
  logic [4:0]  dw;
  logic [8:0]  hdr;
  logic [1:0]  op_now;
  logic [1:0]  ext_now;
  logic [6:0]  addr_now;
  logic [15:0] data_now;
  logic [15:0] rd_word;
  logic        hdr_last;
  logic        dat_last;
  logic        can_prog;
  logic        erase_one;
  logic        erase_all;
  logic        write_one;
  logic        write_all;

  // Cs low clears the partial instruction
  assign lrst_n = i_nrst & link.cs;

  // ----------------------------------------
  // Field decode
  // ----------------------------------------
  always_comb
  begin
    x16      = org_sync[1];
    aw       = x16 ? 5'(`EWP_AW16) : 5'(`EWP_AW8);
    dw       = x16 ? 5'(`EWP_DW16) : 5'(`EWP_DW8);
    hdr      = {hdr_sr, link.di};
    op_now   = x16 ? hdr[7:6] : hdr[8:7];
    ext_now  = x16 ? hdr[5:4] : hdr[6:5];
    addr_now = x16 ? {1'b0, hdr[5:0]} : hdr[6:0];
    data_now = x16 ? {dat_sr[14:0], link.di} : {8'h00, dat_sr[6:0], link.di};
    if (x16)
    begin
      rd_word = mem[addr_now[5:0]];
    end
    else
    begin
      rd_word = {addr_now[0] ? mem[addr_now[6:1]][15:8] : mem[addr_now[6:1]][7:0], 8'h00};
    end
    hdr_last  = (st == EWP_DEV_HDR) && (cnt == aw + 5'h01);
    dat_last  = (st == EWP_DEV_DATA) && (cnt == dw - 5'h01);
    can_prog  = prog_en & ~busy_sync[1];
    erase_one = hdr_last && (op_now == `EWP_OP_ERASE) && can_prog;
    erase_all = hdr_last && (op_now == `EWP_OP_EXT) && (ext_now == `EWP_EXT_ERASE_ALL_CMD) && can_prog;
    write_one = dat_last && (op_q == `EWP_OP_WRITE) && can_prog;
    write_all = dat_last && (op_q == `EWP_OP_EXT) && can_prog;
  end

  function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] v,
                                        input logic wide, input logic hi);
    merge = wide ? v : (hi ? {v[7:0], old[7:0]} : {old[15:8], v[7:0]});
  endfunction

  // ----------------------------------------
  // Link domain synchronisers
  // ----------------------------------------
  always_ff @(posedge link.sk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      org_sync  <= 2'h0;
      busy_sync <= 2'h0;
    end
    else
    begin
      org_sync  <= {org_sync[0], i_word_width_select};
      busy_sync <= {busy_sync[0], o_busy};
    end
  end

  // ----------------------------------------
  // Instruction receiver
  // ----------------------------------------
  always_ff @(posedge link.sk or negedge lrst_n)
  begin
    if (!lrst_n)
    begin
      st       <= EWP_DEV_IDLE;
      cnt      <= 5'h00;
      hdr_sr   <= 8'h00;
      dat_sr   <= 16'h0000;
      op_q     <= 2'h0;
      addr_q   <= 7'h00;
      rd_bit   <= 1'b0;
      rd_act   <= 1'b0;
      cmd_seen <= 1'b0;
    end
    else
    begin
      case (st)
        EWP_DEV_IDLE:
        begin
          if (link.di == `EWP_START_BIT)
          begin
            st       <= EWP_DEV_HDR;
            cnt      <= 5'h00;
            cmd_seen <= 1'b1;
          end
        end
        EWP_DEV_HDR:
        begin
          hdr_sr <= hdr[7:0];
          cnt    <= cnt + 5'h01;
          if (hdr_last)
          begin
            op_q   <= op_now;
            addr_q <= addr_now;
            cnt    <= 5'h00;
            st     <= EWP_DEV_HOLD;
            if (busy_sync[1])
            begin
              st <= EWP_DEV_HOLD;
            end
            else if (op_now == `EWP_OP_READ)
            begin
              st     <= EWP_DEV_READ;
              dat_sr <= rd_word;
              rd_bit <= `EWP_DUMMY_BIT;
              rd_act <= 1'b1;
            end
            else if ((op_now == `EWP_OP_WRITE) ||
                     ((op_now == `EWP_OP_EXT) && (ext_now == `EWP_EXT_WRITE_ALL_CMD)))
            begin
              st     <= EWP_DEV_DATA;
              dat_sr <= 16'h0000;
            end
          end
        end
        EWP_DEV_DATA:
        begin
          dat_sr <= data_now;
          cnt    <= cnt + 5'h01;
          if (dat_last)
          begin
            st <= EWP_DEV_HOLD;
          end
        end
        EWP_DEV_READ:
        begin
          rd_bit <= dat_sr[15];
          dat_sr <= {dat_sr[14:0], 1'b0};
          cnt    <= cnt + 5'h01;
          if (cnt == dw - 5'h01)
          begin
            st <= EWP_DEV_HOLD;
          end
        end
        EWP_DEV_HOLD:
        begin
          st <= EWP_DEV_HOLD;
        end
        default:
        begin
          st <= EWP_DEV_IDLE;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Programming state and cycle start
  // ----------------------------------------
  always_ff @(posedge link.sk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      prog_en  <= 1'b0;
      prog_tgl <= 1'b0;
    end
    else
    begin
      if (hdr_last && (op_now == `EWP_OP_EXT) && (ext_now == `EWP_EXT_EN))
      begin
        prog_en <= 1'b1;
      end
      else if (hdr_last && (op_now == `EWP_OP_EXT) && (ext_now == `EWP_EXT_DIS))
      begin
        prog_en <= 1'b0;
      end
      if (erase_one | erase_all | write_one | write_all)
      begin
        prog_tgl <= ~prog_tgl;
      end
    end
  end

  // ----------------------------------------
  // Array
  // ----------------------------------------
  always_ff @(posedge link.sk)
  begin
    if (erase_one)
    begin
      mem[addr_now[6-x16 -: 6]] <= merge(mem[addr_now[6-x16 -: 6]], `EWP_ERASED, x16, addr_now[0]);
    end
    if (write_one)
    begin
      mem[addr_q[6-x16 -: 6]] <= merge(mem[addr_q[6-x16 -: 6]], data_now, x16, addr_q[0]);
    end
    for (int i = 0; i < `EWP_WORDS; i++)
    begin
      if (erase_all)
      begin
        mem[i] <= `EWP_ERASED;
      end
      else if (write_all)
      begin
        mem[i] <= x16 ? data_now : {data_now[7:0], data_now[7:0]};
      end
    end
  end

  // ----------------------------------------
  // Self-timed cycle and output, system domain
  // ----------------------------------------
  localparam int TW = $clog2(TWP_CYCLES + 1);
  logic [2:0]  tgl_sync;
  logic [1:0]  cs_sync;
  logic        cs_d;
  logic [1:0]  seen_sync;
  logic [1:0]  rda_sync;
  logic [1:0]  rdb_sync;
  logic [1:0]  en_sync;
  logic [TW-1:0] twp_cnt;
  logic        show;

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      tgl_sync  <= 3'h0;
      cs_sync   <= 2'h0;
      cs_d      <= 1'b0;
      seen_sync <= 2'h0;
      rda_sync  <= 2'h0;
      rdb_sync  <= 2'h0;
      en_sync   <= 2'h0;
      o_prog_enabled <= 1'b0;
    end
    else
    begin
      tgl_sync  <= {tgl_sync[1:0], prog_tgl};
      cs_sync   <= {cs_sync[0], link.cs};
      cs_d      <= cs_sync[1];
      seen_sync <= {seen_sync[0], cmd_seen};
      rda_sync  <= {rda_sync[0], rd_act};
      rdb_sync  <= {rdb_sync[0], rd_bit};
      en_sync   <= {en_sync[0], prog_en};
      o_prog_enabled <= en_sync[1];
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      o_busy  <= 1'b0;
      twp_cnt <= '0;
    end
    else if (tgl_sync[2] ^ tgl_sync[1])
    begin
      o_busy  <= 1'b1;
      twp_cnt <= TW'(TWP_CYCLES - 1);
    end
    else if (twp_cnt != '0)
    begin
      twp_cnt <= twp_cnt - 1'b1;
    end
    else
    begin
      o_busy <= 1'b0;
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      show         <= 1'b0;
      link.so_out  <= 1'b1;
      link.so_oe_n <= 1'b1;
    end
    else
    begin
      if (!cs_sync[1] || seen_sync[1])
      begin
        show <= 1'b0;
      end
      else if (!cs_d)
      begin
        show <= o_busy;
      end
      if (!cs_sync[1])
      begin
        link.so_oe_n <= 1'b1;
      end
      else if (show)
      begin
        link.so_oe_n <= 1'b0;
        link.so_out  <= ~o_busy;
      end
      else if (rda_sync[1])
      begin
        link.so_oe_n <= 1'b0;
        link.so_out  <= rdb_sync[1];
      end
      else
      begin
        link.so_oe_n <= 1'b1;
      end
    end
  end

endmodule

// File: logic/ewp_host.sv
// Host end of the three-wire serial command port
`timescale 1ns/10ps
`include "ewp_defines.svh"
module ewp_host
  import ewp_pkg::*;
#(
  parameter int SK_HALF = `EWP_SKH_CYC,
  parameter int TCS     = `EWP_TCS_CYC
)
(
  // System
  input  wire logic  i_clk,
  input  wire logic  i_nrst,
  // Link
  ewp_if.host        link,
  // Command
  input  wire logic  i_req,
  input  ewp_cmd_e   i_cmd,
  input  wire logic [6:0]  i_addr,
  input  wire logic [15:0] i_wdata,
  input  wire logic  i_org,
  // Answer
  output logic       o_ready,
  output logic       o_done,
  output logic [15:0] o_rdata
);

  ewp_hst_st_e st;
  logic [`EWP_FRAME_W-1:0] tx;
  logic [`EWP_FRAME_W-1:0] frame;
  logic [5:0]  nbits;
  logic [5:0]  nb;
  logic [5:0]  bitn;
  logic [4:0]  ph;
  logic [15:0] rx;
  logic [1:0]  so_sync;
  logic        poll;
  logic [1:0]  op;
  logic [6:0]  a7;
  logic [1:0]  ext;
  logic        has_dat;
  logic        is_rd;

  // ----------------------------------------
  // Frame build
  // ----------------------------------------
  always_comb
  begin
    op      = `EWP_OP_EXT;
    ext     = `EWP_EXT_DIS;
    has_dat = 1'b0;
    is_rd   = 1'b0;
    case (i_cmd)
      EWP_CMD_READ:
      begin
        op    = `EWP_OP_READ;
        is_rd = 1'b1;
      end
      EWP_CMD_EN:    ext = `EWP_EXT_EN;
      EWP_CMD_ERASE: op = `EWP_OP_ERASE;
      EWP_CMD_WRITE:
      begin
        op      = `EWP_OP_WRITE;
        has_dat = 1'b1;
      end
      EWP_CMD_ERASE_ALL_CMD:  ext = `EWP_EXT_ERASE_ALL_CMD;
      EWP_CMD_WRITE_ALL_CMD:
      begin
        ext     = `EWP_EXT_WRITE_ALL_CMD;
        has_dat = 1'b1;
      end
      default:       ext = `EWP_EXT_DIS;
    endcase
    if (op == `EWP_OP_EXT)
    begin
      a7 = i_org ? {1'b0, ext, 4'h0} : {ext, 5'h00};
    end
    else
    begin
      a7 = i_addr;
    end
    if (i_org)
    begin
      frame = {`EWP_START_BIT, op, a7[5:0], i_wdata, 1'b0};
      nbits = 6'(3 + `EWP_AW16) + (has_dat ? 6'(`EWP_DW16) : 6'h00) + (is_rd ? 6'(`EWP_DW16 + 1) : 6'h00);
    end
    else
    begin
      frame = {`EWP_START_BIT, op, a7, i_wdata[7:0], 8'h00};
      nbits = 6'(3 + `EWP_AW8) + (has_dat ? 6'(`EWP_DW8) : 6'h00) + (is_rd ? 6'(`EWP_DW8 + 1) : 6'h00);
    end
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      so_sync <= 2'h0;
    end
    else
    begin
      so_sync <= {so_sync[0], link.so};
    end
  end

  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      st      <= EWP_HST_IDLE;
      link.cs <= 1'b0;
      link.sk <= 1'b0;
      link.di <= 1'b0;
      tx      <= '0;
      nb      <= 6'h00;
      bitn    <= 6'h00;
      ph      <= 5'h00;
      rx      <= 16'h0000;
      poll    <= 1'b0;
      o_ready <= 1'b0;
      o_done  <= 1'b0;
      o_rdata <= 16'h0000;
    end
    else
    begin
      o_done <= 1'b0;
      case (st)
        EWP_HST_IDLE:
        begin
          ph <= ph + 5'h01;
          if (ph >= 5'(TCS))
          begin
            ph      <= 5'(TCS);
            o_ready <= 1'b1;
          end
          if (i_req && o_ready)
          begin
            o_ready <= 1'b0;
            link.cs <= 1'b1;
            link.di <= frame[`EWP_FRAME_W-1];
            tx      <= {frame[`EWP_FRAME_W-2:0], 1'b0};
            nb      <= nbits;
            poll    <= (i_cmd == EWP_CMD_ERASE) || (i_cmd == EWP_CMD_WRITE) ||
                       (i_cmd == EWP_CMD_ERASE_ALL_CMD) || (i_cmd == EWP_CMD_WRITE_ALL_CMD);
            bitn    <= 6'h00;
            ph      <= 5'h00;
            st      <= EWP_HST_SHIFT;
          end
        end
        EWP_HST_SHIFT:
        begin
          ph <= ph + 5'h01;
          if (ph == 5'(SK_HALF - 1))
          begin
            ph <= 5'h00;
            if (!link.sk)
            begin
              rx      <= {rx[14:0], so_sync[1]};
              link.sk <= 1'b1;
            end
            else
            begin
              link.sk <= 1'b0;
              if (bitn == nb - 6'h01)
              begin
                link.cs <= 1'b0;
                st      <= EWP_HST_DESEL;
              end
              else
              begin
                bitn    <= bitn + 6'h01;
                link.di <= tx[`EWP_FRAME_W-1];
                tx      <= {tx[`EWP_FRAME_W-2:0], 1'b0};
              end
            end
          end
        end
        EWP_HST_DESEL:
        begin
          ph <= ph + 5'h01;
          if (ph == 5'(TCS - 1))
          begin
            ph      <= 5'h00;
            o_rdata <= i_org ? rx : {8'h00, rx[7:0]};
            link.cs <= poll;
            st      <= poll ? EWP_HST_POLL : EWP_HST_REST;
          end
        end
        EWP_HST_POLL:
        begin
          if (ph != 5'(2 * TCS))
          begin
            ph <= ph + 5'h01;
          end
          else if (so_sync[1])
          begin
            link.cs <= 1'b0;
            ph      <= 5'h00;
            st      <= EWP_HST_REST;
          end
        end
        EWP_HST_REST:
        begin
          o_done <= 1'b1;
          ph     <= 5'h01;
          st     <= EWP_HST_IDLE;
        end
        default:
        begin
          st <= EWP_HST_IDLE;
        end
      endcase
    end
  end

endmodule

// File: pkg/ewp_defines.svh
// Constants of the three-wire serial memory command port
`ifndef EWP_DEFINES_SVH
`define EWP_DEFINES_SVH

// ----------------------------------------
// Instruction fields
// ----------------------------------------
`define EWP_START_BIT   1'b1
`define EWP_DUMMY_BIT   1'b0
`define EWP_OP_EXT      2'h0
`define EWP_OP_WRITE    2'h1
`define EWP_OP_READ     2'h2
`define EWP_OP_ERASE    2'h3
`define EWP_EXT_DIS     2'h0
`define EWP_EXT_WRITE_ALL_CMD    2'h1
`define EWP_EXT_ERASE_ALL_CMD    2'h2
`define EWP_EXT_EN      2'h3
`define EWP_ERASED      16'hffff

// ----------------------------------------
// Organisation
// ----------------------------------------
`define EWP_AW8         7
`define EWP_AW16        6
`define EWP_DW8         8
`define EWP_DW16        16
`define EWP_WORDS       64
`define EWP_FRAME_W     26

// ----------------------------------------
// Timing
// ----------------------------------------
`define EWP_CLK_NS      40
`define EWP_TWP_NS      1500000
`define EWP_TWP_CYC     ((`EWP_TWP_NS + `EWP_CLK_NS - 1) / `EWP_CLK_NS)
`define EWP_TCS_NS      250
`define EWP_TCS_CYC     ((`EWP_TCS_NS + `EWP_CLK_NS - 1) / `EWP_CLK_NS)
`define EWP_SKH_NS      250
`define EWP_SKH_CYC     ((`EWP_SKH_NS + `EWP_CLK_NS - 1) / `EWP_CLK_NS)

`endif

// File: pkg/ewp_if.sv
// Three-wire serial link between host and memory device
`timescale 1ns/10ps
interface ewp_if;
  logic cs;
  logic sk;
  logic di;
  logic so_out;
  logic so_oe_n;
  logic so;

  // Undriven serial output reads high
  assign so = so_oe_n ? 1'b1 : so_out;

  modport dev (input cs, input sk, input di, output so_out, output so_oe_n);
  modport host (output cs, output sk, output di, input so);
endinterface

// File: pkg/ewp_pkg.sv
// Types of the three-wire serial memory command port
package ewp_pkg;

  typedef enum logic [2:0] {
    EWP_CMD_READ,
    EWP_CMD_EN,
    EWP_CMD_DIS,
    EWP_CMD_ERASE,
    EWP_CMD_WRITE,
    EWP_CMD_ERASE_ALL_CMD,
    EWP_CMD_WRITE_ALL_CMD
  } ewp_cmd_e;

  typedef enum {
    EWP_DEV_IDLE,
    EWP_DEV_HDR,
    EWP_DEV_DATA,
    EWP_DEV_READ,
    EWP_DEV_HOLD
  } ewp_dev_st_e;

  typedef enum {
    EWP_HST_IDLE,
    EWP_HST_SHIFT,
    EWP_HST_DESEL,
    EWP_HST_POLL,
    EWP_HST_REST
  } ewp_hst_st_e;

endpackage

// File: sim/ewp_link_monitor.sv
// Link checker for the three-wire serial command port
`timescale 1ns/10ps
module ewp_link_monitor
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Link wires
  input wire logic cs,
  input wire logic sk,
  input wire logic di,
  input wire logic so_out,
  input wire logic so_oe_n,
  input wire logic so
);
  logic       sk_q;
  logic [4:0] nrise;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_nrst);

  // ----------------------------------------
  // Helper logic
  // ----------------------------------------
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      sk_q <= 1'b0;
    else
      sk_q <= sk;
  end

  // Shift clock rises within the frame
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
      nrise <= 5'h00;
    else if (!cs)
      nrise <= 5'h00;
    else if (sk && !sk_q && nrise != 5'h1f)
      nrise <= nrise + 5'h01;
  end

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_cs_gap;
    $fell(cs) |-> !cs [*7];
  endproperty
  a_cs_gap: assert property (p_cs_gap)
    else $error("chip select low time too short");

  property p_start;
    $rose(sk) && nrise == 5'h00 |-> di;
  endproperty
  a_start: assert property (p_start)
    else $error("first bit of frame is not one");

  property p_di_hold;
    sk && $past(sk) |-> $stable(di);
  endproperty
  a_di_hold: assert property (p_di_hold)
    else $error("serial input moved while clock high");

  property p_sk_still;
    !cs [*8] |-> !sk;
  endproperty
  a_sk_still: assert property (p_sk_still)
    else $error("shift clock runs outside frame");

  property p_release;
    $fell(cs) |-> ##[0:6] so_oe_n;
  endproperty
  a_release: assert property (p_release)
    else $error("serial output still driven after deselect");

  property p_status_hold;
    cs && nrise == 5'h00 && !so_oe_n && so_out |=> !cs || so_oe_n || so_out;
  endproperty
  a_status_hold: assert property (p_status_hold)
    else $error("ready status fell back to busy");

  property p_shift_edge;
    cs && nrise != 5'h00 && !so_oe_n && $changed(so_out) |-> sk;
  endproperty
  a_shift_edge: assert property (p_shift_edge)
    else $error("read data changed outside clock high phase");

  property p_frame_len;
    $fell(cs) && nrise != 5'h00 |-> nrise inside {5'h09, 5'h0a, 5'h12, 5'h13, 5'h19, 5'h1a};
  endproperty
  a_frame_len: assert property (p_frame_len)
    else $error("frame bit count wrong");

  // ----------------------------------------
  // Coverage
  // ----------------------------------------
  c_read: cover property ($fell(cs) && nrise == 5'h1a);
  c_write: cover property ($fell(cs) && nrise == 5'h19);
  c_ready: cover property (cs && nrise == 5'h00 && !so_oe_n && so);
  c_busy: cover property (cs && nrise == 5'h00 && !so_oe_n && !so);
endmodule

// File: sim/test_three_wire_eeprom_command_port.sv
// Testbench of the three-wire serial command port, both ends joined
`timescale 1ns/10ps
module test_three_wire_eeprom_command_port
  import ewp_pkg::*;
;
  logic        i_clk;
  logic        i_nrst;
  logic        req;
  ewp_cmd_e    cmd;
  logic [6:0]  addr;
  logic [15:0] wdata;
  logic        word_width_select;
  logic        ready;
  logic        done;
  logic [15:0] rdata;
  logic        busy;
  logic        prog_en;
  logic        saw_busy;
  int          error_cnt;
  int          check_count;

  ewp_if link_if ();

  ewp_device #(.TWP_CYCLES(50)) u_ewp_device (.i_clk(i_clk), .i_nrst(i_nrst), .link(link_if),
    .i_word_width_select(word_width_select), .o_busy(busy), .o_prog_enabled(prog_en));

  ewp_host #(.SK_HALF(7), .TCS(7)) u_ewp_host (.i_clk(i_clk), .i_nrst(i_nrst), .link(link_if),
    .i_req(req), .i_cmd(cmd), .i_addr(addr), .i_wdata(wdata), .i_org(word_width_select),
    .o_ready(ready), .o_done(done), .o_rdata(rdata));

  ewp_link_monitor m_link (.i_clk(i_clk), .i_nrst(i_nrst), .cs(link_if.cs), .sk(link_if.sk),
    .di(link_if.di), .so_out(link_if.so_out), .so_oe_n(link_if.so_oe_n), .so(link_if.so));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
  begin
    check_count++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  end
  endtask

  task send(input ewp_cmd_e c, input logic [6:0] a, input logic [15:0] d);
    int n;
  begin
    n = 0;
    while (ready !== 1'b1 && n < 4000)
    begin
      @(negedge i_clk);
      n++;
    end
    @(posedge i_clk);
    cmd <= c;
    addr <= a;
    wdata <= d;
    req <= 1'b1;
    @(posedge i_clk);
    req <= 1'b0;
    saw_busy = 1'b0;
    n = 0;
    do
    begin
      @(negedge i_clk);
      if (busy === 1'b1)
        saw_busy = 1'b1;
      n++;
    end while (done !== 1'b1 && n < 4000);
    check("done", {15'h0000, done}, 16'h0001);
  end
  endtask

  task rd(input logic [6:0] a, input logic [15:0] exp, input logic [15:0] m);
  begin
    send(EWP_CMD_READ, a, 16'h0000);
    check("rdata", rdata & m, exp);
  end
  endtask

  task stop_test;
  begin
    if (error_cnt == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  end
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task t_powerup;
  begin
    check("prog_en", {15'h0000, prog_en}, 16'h0000);
    send(EWP_CMD_WRITE, 7'h05, 16'h1234);
    check("saw_busy", {15'h0000, saw_busy}, 16'h0000);
  end
  endtask

  task t_enable_erase_all;
  begin
    send(EWP_CMD_EN, 7'h00, 16'h0000);
    check("prog_en", {15'h0000, prog_en}, 16'h0001);
    send(EWP_CMD_ERASE_ALL_CMD, 7'h00, 16'h0000);
    check("saw_busy", {15'h0000, saw_busy}, 16'h0001);
    rd(7'h00, 16'hffff, 16'hffff);
    rd(7'h3f, 16'hffff, 16'hffff);
  end
  endtask

  task t_write_read;
  begin
    send(EWP_CMD_WRITE, 7'h05, 16'ha5c3);
    check("saw_busy", {15'h0000, saw_busy}, 16'h0001);
    send(EWP_CMD_WRITE, 7'h06, 16'h0f0f);
    rd(7'h05, 16'ha5c3, 16'hffff);
    rd(7'h06, 16'h0f0f, 16'hffff);
  end
  endtask

  task t_erase;
  begin
    send(EWP_CMD_ERASE, 7'h05, 16'h0000);
    check("saw_busy", {15'h0000, saw_busy}, 16'h0001);
    rd(7'h05, 16'hffff, 16'hffff);
    rd(7'h06, 16'h0f0f, 16'hffff);
    check("prog_en", {15'h0000, prog_en}, 16'h0001);
  end
  endtask

  task t_write_all;
  begin
    send(EWP_CMD_WRITE_ALL_CMD, 7'h00, 16'h3c3c);
    rd(7'h00, 16'h3c3c, 16'hffff);
    rd(7'h3f, 16'h3c3c, 16'hffff);
  end
  endtask

  task t_disable;
  begin
    send(EWP_CMD_DIS, 7'h00, 16'h0000);
    check("prog_en", {15'h0000, prog_en}, 16'h0000);
    send(EWP_CMD_WRITE, 7'h07, 16'h0000);
    check("saw_busy", {15'h0000, saw_busy}, 16'h0000);
    rd(7'h07, 16'h3c3c, 16'hffff);
  end
  endtask

  task t_byte_org;
  begin
    @(posedge i_clk);
    i_nrst <= 1'b0;
    word_width_select <= 1'b0;
    repeat (5) @(posedge i_clk);
    i_nrst <= 1'b1;
    @(negedge i_clk);
    check("prog_en", {15'h0000, prog_en}, 16'h0000);
    send(EWP_CMD_EN, 7'h00, 16'h0000);
    send(EWP_CMD_WRITE, 7'h09, 16'h005a);
    rd(7'h08, 16'h003c, 16'h00ff);
    rd(7'h09, 16'h005a, 16'h00ff);
  end
  endtask

  // ----------------------------------------
  // Clock, watchdog and main sequence
  // ----------------------------------------
  initial
  begin
    i_clk = 1'b0;
    forever #20 i_clk = ~i_clk;
  end

  initial
  begin
    #1000000;
    error_cnt++;
    stop_test;
  end

  initial
  begin
    i_nrst = 1'b0;
    req = 1'b0;
    cmd = EWP_CMD_READ;
    addr = 7'h00;
    wdata = 16'h0000;
    word_width_select = 1'b1;
    saw_busy = 1'b0;
    error_cnt = 0;
    check_count = 0;
    repeat (5) @(posedge i_clk);
    i_nrst <= 1'b1;
    t_powerup;
    t_enable_erase_all;
    t_write_read;
    t_erase;
    t_write_all;
    t_disable;
    t_byte_org;
    stop_test;
  end
endmodule
